// >>> serial_pkg.sv
/*
 * Shared constants, types and helper functions for the dual serial port block:
 * register indices, field positions, reset values, bit timing counts, modes,
 * sequencer states and the per-port activity event carrier.
 * Assumes a 32-bit APB with word-aligned registers at four times their index.
 */
`default_nettype none

package serial_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_P0_PORT0_SLAVE_ADDRESS = 8'ha9;
	localparam logic [7:0] IDX_P1_PORT0_SLAVE_ADDRESS = 8'haa;
	localparam logic [7:0] IDX_P0_MASK  = 8'hb9;
	localparam logic [7:0] IDX_P1_MASK  = 8'hba;
	localparam logic [7:0] IDX_P1_CTRL  = 8'hc0;
	localparam logic [7:0] IDX_P1_BUF   = 8'hc1;
	localparam logic [7:0] IDX_CONFIG   = 8'hc3;
	localparam logic [7:0] IDX_POWER    = 8'hc4;
	localparam logic [7:0] IDX_STATUS   = 8'hc5;

	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_MODE_HI  = 7;
	localparam int unsigned CTRL_MODE_LO  = 6;
	localparam int unsigned CTRL_MULTI    = 5;
	localparam int unsigned CTRL_REN      = 4;
	localparam int unsigned CTRL_TX9      = 3;
	localparam int unsigned CTRL_RX9      = 2;
	localparam int unsigned CTRL_TI       = 1;
	localparam int unsigned CTRL_RI       = 0;
	localparam int unsigned CFG_FE_SEL    = 7;
	localparam int unsigned CFG_BAUD_DBL  = 6;
	localparam int unsigned POWER_CD_HI   = 7;
	localparam int unsigned POWER_CD_LO   = 6;
	localparam int unsigned POWER_SWB     = 5;
	localparam int unsigned STAT_P1_TX    = 3;
	localparam int unsigned STAT_P1_RX    = 2;
	localparam int unsigned STAT_P0_TX    = 1;
	localparam int unsigned STAT_P0_RX    = 0;

	// ==========================================================
	// Reset and reserved values
	localparam logic [7:0] REG8_RST     = 8'h00;
	localparam logic [1:0] CD_DIV4      = 2'h1;
	localparam logic [1:0] CD_RESERVED  = 2'h0;
	localparam logic       SWB_RST      = 1'b0;

	// ==========================================================
	// Timing counts, in pclk cycles or sample ticks
	localparam logic [3:0] M0_SLOW_LAST = 4'hb;  // 12 clocks per shift bit
	localparam logic [3:0] M0_FAST_LAST = 4'h3;  // 4 clocks per shift bit
	localparam logic [3:0] M0_SLOW_HALF = 4'h6;
	localparam logic [3:0] M0_FAST_HALF = 4'h2;
	localparam logic [1:0] M2_SLOW_LAST = 2'h3;  // 64 clocks per bit over 16 ticks
	localparam logic [1:0] M2_FAST_LAST = 2'h1;  // 32 clocks per bit over 16 ticks
	localparam logic [3:0] OS_LAST      = 4'hf;  // 16 sample ticks per bit
	localparam logic [3:0] OS_MID       = 4'h7;
	localparam logic [2:0] BIT_LAST     = 3'h7;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {MODE_SYNC, MODE_ASYNC8, MODE_ASYNC9_FIXED, MODE_ASYNC9_VAR} serial_mode_t;
	typedef enum logic [2:0] {TX_IDLE, TX_SHIFT, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_SHIFT, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_t;

	typedef struct packed {
		logic tx_start;
		logic tx_set;
		logic rx_start;
		logic rx_set;
		logic rx_abort;
	} port_events_t;

	// ==========================================================
	// Functions
	function automatic logic addr_match(input logic [7:0] data, input logic [7:0] port0_slave_address,
		input logic [7:0] mask);
		addr_match = ((data ^ port0_slave_address) & mask) == 8'h00;
	endfunction

	function automatic logic reg_hit(input logic [11:0] paddr, input logic [7:0] idx);
		reg_hit = paddr == {2'h0, idx, 2'h0};
	endfunction

	function automatic logic m0_end(input logic [3:0] cnt, input logic fast);
		m0_end = cnt == (fast ? M0_FAST_LAST : M0_SLOW_LAST);
	endfunction

endpackage

`default_nettype wire

// >>> serial_activity_monitor.sv
/*
 * Per-port activity tracker and masked slave address comparator.
 * Assumes one-cycle event pulses from the port's sequencer, synchronous to pclk.
 */
`default_nettype none

module serial_activity_monitor import serial_pkg::*; (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	input  wire port_events_t events,
	input  wire logic [7:0]   rx_byte,
	input  wire logic [7:0]   slave_address,
	input  wire logic [7:0]   address_mask,
	output logic              tx_activity,
	output logic              rx_activity,
	output logic              address_match
);

	typedef struct packed {
		logic tx;
		logic rx;
		logic match;
	} mon_state_t;

	mon_state_t s;
	mon_state_t next_s;

	// ==========================================================
	// Activity and match
	always_comb begin
		next_s = s;
		if (clk_en) begin
			if (events.tx_set)
				next_s.tx = 1'b0;  // R16 R18
			if (events.tx_start)
				next_s.tx = 1'b1;  // R16 R18
			if (events.rx_set || events.rx_abort)
				next_s.rx = 1'b0;  // R17 R18
			if (events.rx_start)
				next_s.rx = 1'b1;  // R17 R18
			next_s.match = addr_match(rx_byte, slave_address, address_mask);  // R13 R14 R15
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tx_activity   = s.tx;
	assign rx_activity   = s.rx;
	assign address_match = s.match;

endmodule

`default_nettype wire

// >>> dual_serial_port_addr_match.sv
/*
 * Second serial port with automatic address recognition, activity status and
 * clock divide switchback, reached over APB.
 * Assumes pins and baud ticks synchronous to pclk; port 0's engine lives outside
 * and reports its events here.
 */
// Added by the designer: the APB register port.
// Function
// R1 - Two mode bits pick synchronous, 10-bit async, fixed 11-bit or variable 11-bit.
// R2 - Control bit 7 is mode bit or sticky framing error, per select bit.
// R3 - Modes 2/3 with multiprocessor set: no receive flag when ninth bit is 0.
// R4 - Mode 1 with multiprocessor set: no receive flag without valid stop bit.
// R5 - Mode 0 shift clock is divide by 12, or by 4 with multiprocessor set.
// R6 - Reception happens only while receive enable is 1.
// R7 - Modes 2/3 send the software ninth bit as the ninth data bit.
// R8 - Received ninth bit holds bit 9, or stop bit in mode 1 without multiprocessor.
// R9 - Transmit flag sets after bit 8 in mode 0, else at stop start.
// R10 - Receive flag sets after bit 8 in mode 0, else mid stop bit.
// R11 - Data buffer reads return receive register, writes load transmit register.
// R12 - Software loads each slave address register with its given or broadcast address.
// R13 - Set mask bits compare address bits; cleared mask bits are don't care.
// R14 - An all-zero mask accepts any incoming address.
// R15 - Port 0 uses its own address and mask the same way.
// R16 - Transmit activity set while sending, cleared when transmit flag sets.
// R17 - Receive activity set while receiving, cleared when receive flag sets.
// R18 - Port 0 has equivalent transmit and receive activity bits.
// R19 - Clock divide writes ignored while any activity and switchback are set.
// R20 - With switchback, reception start forces clock divide to divide by 4.
// R21 - Writing the transmit buffer starts one frame in the current mode; the code starts it only while transmit and receive sequencers are idle.
// R22 - Each port's transmit or receive flag forms its interrupt request.

`default_nettype none

module dual_serial_port_addr_match import serial_pkg::*; (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	input  wire logic [11:0]  paddr,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  wire logic         port1_rxd_in,
	output logic              port1_rxd_out,
	output logic              port1_rxd_oe,
	output logic              port1_txd,
	input  wire logic         port1_baud_tick,
	input  wire port_events_t port0_events,
	input  wire logic [7:0]   port0_rx_byte,
	input  wire logic         port0_tx_done_flag,
	input  wire logic         port0_rx_done_flag,
	output logic              port0_addr_match,
	output logic              port0_irq,
	output logic              port1_irq,
	output logic [1:0]        clock_divide
);

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [7:0]  saddr0;
		logic [7:0]  mask0;
		logic [7:0]  port1_slave_address;
		logic [7:0]  mask1;
		logic        mode_hi;
		logic        frame_err;
		logic        mode_lo;
		logic        multi;
		logic        ren;
		logic        tx9;
		logic        rx9_flag;
		logic        ti;
		logic        ri;
		logic [7:0]  tx_buf;
		logic [7:0]  rx_buf;
		logic        fe_sel;
		logic        baud_dbl;
		logic        switchback_enable;
		logic [1:0]  cd;
		logic [1:0]  pre;
		tx_state_t   tx_state;
		logic [2:0]  tx_bit;
		logic [3:0]  tx_sub;
		logic [7:0]  tx_shift;
		logic        txd;
		logic        rxd_out;
		logic        rxd_oe;
		rx_state_t   rx_state;
		logic [2:0]  rx_bit;
		logic [3:0]  rx_sub;
		logic [7:0]  rx_shift;
		logic        rx_ninth;
		logic        rx_prev;
		logic        irq0;
		logic        irq1;
	} top_state_t;

	top_state_t   s;
	top_state_t   next_s;
	port_events_t p1_ev;
	serial_mode_t mode;
	logic         p1_tx_act;
	logic         p1_rx_act;
	logic         p0_tx_act;
	logic         p0_rx_act;
	logic         any_act;
	logic         mapped;
	logic [7:0]   rd;
	logic         wr;
	logic         tick;
	logic         tx_end;
	logic         rx_mid;
	logic         rx_end;
	logic [3:0]   half;
	logic         stop_bit;
	logic         accept;
	logic [1:0]   new_cd;

	// ==========================================================
	// Activity trackers
	serial_activity_monitor port1_monitor (
		.pclk          (pclk),
		.presetn       (presetn),
		.clk_en        (clk_en),
		.events        (p1_ev),
		.rx_byte       (s.rx_shift),
		.slave_address (s.port1_slave_address),
		.address_mask  (s.mask1),
		.tx_activity   (p1_tx_act),
		.rx_activity   (p1_rx_act),
		.address_match ()
	);

	serial_activity_monitor port0_monitor (
		.pclk          (pclk),
		.presetn       (presetn),
		.clk_en        (clk_en),
		.events        (port0_events),
		.rx_byte       (port0_rx_byte),
		.slave_address (s.saddr0),
		.address_mask  (s.mask0),
		.tx_activity   (p0_tx_act),
		.rx_activity   (p0_rx_act),
		.address_match (port0_addr_match)  // R15
	);

	assign any_act = p1_tx_act | p1_rx_act | p0_tx_act | p0_rx_act;
	assign mode    = serial_mode_t'({s.mode_hi, s.mode_lo});  // R1

	// ==========================================================
	// Register read mux
	always_comb begin
		rd     = REG8_RST;
		mapped = 1'b1;
		if (reg_hit(paddr, IDX_P0_PORT0_SLAVE_ADDRESS))
			rd = s.saddr0;
		else if (reg_hit(paddr, IDX_P1_PORT0_SLAVE_ADDRESS))
			rd = s.port1_slave_address;
		else if (reg_hit(paddr, IDX_P0_MASK))
			rd = s.mask0;
		else if (reg_hit(paddr, IDX_P1_MASK))
			rd = s.mask1;
		else if (reg_hit(paddr, IDX_P1_CTRL))
			rd = {s.fe_sel ? s.frame_err : s.mode_hi, s.mode_lo, s.multi, s.ren,
				s.tx9, s.rx9_flag, s.ti, s.ri};  // R2
		else if (reg_hit(paddr, IDX_P1_BUF))
			rd = s.rx_buf;  // R11
		else if (reg_hit(paddr, IDX_CONFIG))
			rd = {s.fe_sel, s.baud_dbl, 6'h00};
		else if (reg_hit(paddr, IDX_POWER))
			rd = {s.cd, s.switchback_enable, 5'h00};
		else if (reg_hit(paddr, IDX_STATUS))
			rd = {4'h0, p1_tx_act, p1_rx_act, p0_tx_act, p0_rx_act};
		else
			mapped = 1'b0;
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s   = s;
		p1_ev    = '0;
		wr       = psel && penable && s.pready && pwrite;
		tick     = (mode == MODE_ASYNC9_FIXED) ?
			(s.pre == (s.baud_dbl ? M2_FAST_LAST : M2_SLOW_LAST)) : port1_baud_tick;
		tx_end   = tick && (s.tx_sub == OS_LAST);
		rx_mid   = tick && (s.rx_sub == OS_MID);
		rx_end   = tick && (s.rx_sub == OS_LAST);
		half     = s.multi ? M0_FAST_HALF : M0_SLOW_HALF;  // R5
		stop_bit = port1_rxd_in;
		accept   = 1'b1;
		new_cd   = pwdata[POWER_CD_HI:POWER_CD_LO];
		if (clk_en) begin
			// APB slave: answer one cycle into the access phase
			next_s.pready  = psel && penable && !s.pready;
			next_s.pslverr = psel && penable && !s.pready && !mapped;
			if (psel && penable && !s.pready)
				next_s.prdata = {24'h000000, rd};
			next_s.pre = tick ? 2'h0 : s.pre + 2'h1;
			next_s.rx_prev = port1_rxd_in;

			// Software writes
			if (wr && reg_hit(paddr, IDX_P0_PORT0_SLAVE_ADDRESS))
				next_s.saddr0 = pwdata[7:0];
			if (wr && reg_hit(paddr, IDX_P1_PORT0_SLAVE_ADDRESS))
				next_s.port1_slave_address = pwdata[7:0];
			if (wr && reg_hit(paddr, IDX_P0_MASK))
				next_s.mask0 = pwdata[7:0];
			if (wr && reg_hit(paddr, IDX_P1_MASK))
				next_s.mask1 = pwdata[7:0];
			if (wr && reg_hit(paddr, IDX_CONFIG)) begin
				next_s.fe_sel   = pwdata[CFG_FE_SEL];
				next_s.baud_dbl = pwdata[CFG_BAUD_DBL];
			end
			if (wr && reg_hit(paddr, IDX_P1_CTRL)) begin
				if (s.fe_sel)
					next_s.frame_err = pwdata[CTRL_MODE_HI];  // R2
				else
					next_s.mode_hi = pwdata[CTRL_MODE_HI];
				next_s.mode_lo  = pwdata[CTRL_MODE_LO];
				next_s.multi    = pwdata[CTRL_MULTI];
				next_s.ren      = pwdata[CTRL_REN];
				next_s.tx9      = pwdata[CTRL_TX9];
				next_s.rx9_flag = pwdata[CTRL_RX9];
				next_s.ti       = pwdata[CTRL_TI];
				next_s.ri       = pwdata[CTRL_RI];
			end
			if (wr && reg_hit(paddr, IDX_POWER)) begin
				next_s.switchback_enable = pwdata[POWER_SWB];
				// Divide changes must pass through divide by 4
				if (!(s.switchback_enable && any_act) && new_cd != CD_RESERVED &&
					(new_cd == CD_DIV4 || s.cd == CD_DIV4))
					next_s.cd = new_cd;  // R19
			end
			if (wr && reg_hit(paddr, IDX_P1_BUF)) begin
				next_s.tx_buf = pwdata[7:0];  // R11
				if (s.tx_state == TX_IDLE && s.rx_state == RX_IDLE) begin
					next_s.tx_shift = pwdata[7:0];
					next_s.tx_bit   = 3'h0;
					next_s.tx_sub   = 4'h0;
					p1_ev.tx_start  = 1'b1;
					if (mode == MODE_SYNC) begin
						next_s.tx_state = TX_SHIFT;  // R21
						next_s.txd      = 1'b0;
						next_s.rxd_out  = pwdata[0];
						next_s.rxd_oe   = 1'b1;
					end else begin
						next_s.tx_state = TX_START;  // R21
						next_s.txd      = 1'b0;
					end
				end
			end

			// Transmit sequencer
			case (s.tx_state)
				TX_IDLE: begin
				end
				TX_SHIFT: begin
					next_s.tx_sub = s.tx_sub + 4'h1;
					next_s.txd    = (s.tx_sub + 4'h1) >= half;
					if (m0_end(s.tx_sub, s.multi)) begin  // R5
						next_s.tx_sub   = 4'h0;
						next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
						next_s.tx_bit   = s.tx_bit + 3'h1;
						next_s.txd      = 1'b0;
						next_s.rxd_out  = s.tx_shift[1];
						if (s.tx_bit == BIT_LAST) begin
							next_s.ti       = 1'b1;  // R9
							p1_ev.tx_set    = 1'b1;
							next_s.tx_state = TX_IDLE;
							next_s.txd      = 1'b1;
							next_s.rxd_oe   = 1'b0;
						end
					end
				end
				TX_START, TX_DATA, TX_NINTH, TX_STOP: begin
					if (tick)
						next_s.tx_sub = s.tx_sub + 4'h1;
					if (tx_end) begin
						case (s.tx_state)
							TX_START: begin
								next_s.tx_state = TX_DATA;
								next_s.txd      = s.tx_shift[0];
							end
							TX_DATA: begin
								next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
								next_s.tx_bit   = s.tx_bit + 3'h1;
								next_s.txd      = s.tx_shift[1];
								if (s.tx_bit == BIT_LAST) begin
									if (mode == MODE_ASYNC8) begin
										next_s.tx_state = TX_STOP;
										next_s.txd      = 1'b1;
										next_s.ti       = 1'b1;  // R9
										p1_ev.tx_set    = 1'b1;
									end else begin
										next_s.tx_state = TX_NINTH;
										next_s.txd      = s.tx9;  // R7
									end
								end
							end
							TX_NINTH: begin
								next_s.tx_state = TX_STOP;
								next_s.txd      = 1'b1;
								next_s.ti       = 1'b1;  // R9
								p1_ev.tx_set    = 1'b1;
							end
							default: begin
								next_s.tx_state = TX_IDLE;
							end
						endcase
					end
				end
				default: begin
					next_s.tx_state = TX_IDLE;
				end
			endcase

			// Receive sequencer
			case (s.rx_state)
				RX_IDLE: begin
					next_s.rx_sub = 4'h0;
					next_s.rx_bit = 3'h0;
					if (s.ren && mode == MODE_SYNC && !s.ri && s.tx_state == TX_IDLE) begin  // R6
						next_s.rx_state = RX_SHIFT;
						next_s.txd      = 1'b0;
						p1_ev.rx_start  = 1'b1;
					end else if (s.ren && mode != MODE_SYNC && s.rx_prev && !port1_rxd_in) begin  // R6
						next_s.rx_state = RX_START;
						p1_ev.rx_start  = 1'b1;
					end
				end
				RX_SHIFT: begin
					next_s.rx_sub = s.rx_sub + 4'h1;
					next_s.txd    = (s.rx_sub + 4'h1) >= half;
					if (s.rx_sub == half - 4'h1)
						next_s.rx_shift = {port1_rxd_in, s.rx_shift[7:1]};
					if (m0_end(s.rx_sub, s.multi)) begin  // R5
						next_s.rx_sub = 4'h0;
						next_s.rx_bit = s.rx_bit + 3'h1;
						next_s.txd    = 1'b0;
						if (s.rx_bit == BIT_LAST) begin
							next_s.rx_state = RX_IDLE;
							next_s.txd      = 1'b1;
							next_s.ri       = 1'b1;  // R10
							next_s.rx_buf   = s.rx_shift;
							p1_ev.rx_set    = 1'b1;
						end
					end
				end
				RX_START, RX_DATA, RX_NINTH, RX_STOP: begin
					if (tick)
						next_s.rx_sub = s.rx_sub + 4'h1;
					if (rx_mid) begin
						case (s.rx_state)
							RX_START: begin
								if (port1_rxd_in) begin
									next_s.rx_state = RX_IDLE;
									p1_ev.rx_abort  = 1'b1;
								end
							end
							RX_DATA: begin
								next_s.rx_shift = {port1_rxd_in, s.rx_shift[7:1]};
							end
							RX_NINTH: begin
								next_s.rx_ninth = port1_rxd_in;
							end
							default: begin
								next_s.rx_state = RX_IDLE;
								if (!stop_bit)
									next_s.frame_err = 1'b1;  // R2
								if (mode == MODE_ASYNC8)
									accept = !s.multi || stop_bit;  // R4
								else
									accept = !s.multi ||
										(s.rx_ninth && addr_match(s.rx_shift, s.port1_slave_address, s.mask1));  // R3 R13 R14
								if (accept) begin
									next_s.ri       = 1'b1;  // R10
									next_s.rx_buf   = s.rx_shift;
									next_s.rx9_flag = (mode == MODE_ASYNC8) ? stop_bit : s.rx_ninth;  // R8
									p1_ev.rx_set    = 1'b1;
								end else begin
									p1_ev.rx_abort = 1'b1;
								end
							end
						endcase
					end
					if (rx_end) begin
						next_s.rx_sub = 4'h0;
						case (s.rx_state)
							RX_START: begin
								next_s.rx_state = RX_DATA;
							end
							RX_DATA: begin
								next_s.rx_bit = s.rx_bit + 3'h1;
								if (s.rx_bit == BIT_LAST)
									next_s.rx_state = (mode == MODE_ASYNC8) ? RX_STOP : RX_NINTH;
							end
							default: begin
								next_s.rx_state = RX_STOP;
							end
						endcase
					end
				end
				default: begin
					next_s.rx_state = RX_IDLE;
				end
			endcase

			// Reception start pulls the clock back to divide by 4
			if (s.switchback_enable && (p1_ev.rx_start || port0_events.rx_start))
				next_s.cd = CD_DIV4;  // R20
			next_s.irq1 = next_s.ti | next_s.ri;  // R22
			next_s.irq0 = port0_tx_done_flag | port0_rx_done_flag;  // R22
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.cd       <= CD_DIV4;
			s.switchback_enable      <= SWB_RST;
			s.txd      <= 1'b1;
			s.rxd_out  <= 1'b1;
			s.rx_prev  <= 1'b1;
			s.tx_state <= TX_IDLE;
			s.rx_state <= RX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign pready        = s.pready;
	assign prdata        = s.prdata;
	assign pslverr       = s.pslverr;
	assign port1_rxd_out = s.rxd_out;
	assign port1_rxd_oe  = s.rxd_oe;
	assign port1_txd     = s.txd;
	assign port0_irq     = s.irq0;
	assign port1_irq     = s.irq1;
	assign clock_divide  = s.cd;

endmodule

`default_nettype wire

// >>> serial_remote_node.sv
/* Remote serial node at the far end of port 1: sends frames on the receive pin and captures
   transmitted frames. Assumes a baud tick on every other pclk cycle, 16 ticks per bit. */
`default_nettype none
module serial_remote_node (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic txd,
	output var logic  rxd,
	output var logic  baud_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT_CLKS = 32;
	initial rxd = 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			baud_tick <= 1'b0;
		else
			baud_tick <= ~baud_tick;
	end
	// ==========================================================
	// Frame tasks, LSB first, start bit in f[0]
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (BIT_CLKS) @(posedge pclk);
		end
		rxd <= 1'b1;
	endtask
	task automatic recv(output logic [10:0] f, input int n);
		int k;
		f = 11'h7ff;
		k = 0;
		while (txd !== 1'b0 && k < 4000) begin
			@(posedge pclk);
			k++;
		end
		repeat (BIT_CLKS / 2) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			f[i] = txd;
			repeat (BIT_CLKS) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// >>> dual_serial_port_addr_match_asserts.sv
/* Port-level checker for the serial port block, bound to its top module.
   Assumes one pclk domain and an APB master that holds requests until pready. */
`default_nettype none
module dual_serial_port_addr_match_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        port0_tx_done_flag,
	input wire logic        port0_rx_done_flag,
	input wire logic        port0_irq,
	input wire logic [1:0]  clock_divide
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_one_wait: assert property (psel && penable && !pready && clk_en |=> pready) else $error("late answer");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
	a_data_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
	a_irq_follows_flags: assert property (clk_en |=> port0_irq == ($past(port0_tx_done_flag) ||
		$past(port0_rx_done_flag))) else $error("port 0 request wrong");
	a_divide_legal: assert property (clock_divide != 2'h0) else $error("reserved divide");
	a_divide_via_four: assert property ($changed(clock_divide) |-> clock_divide == 2'h1 ||
		$past(clock_divide) == 2'h1) else $error("divide skipped divide by 4");
	c_refused: cover property (pslverr);
	c_divide_64: cover property (clock_divide == 2'h2);
	c_port0_irq: cover property (port0_irq);
endmodule
bind dual_serial_port_addr_match dual_serial_port_addr_match_asserts dual_serial_port_addr_match_asserts_i (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .port0_tx_done_flag(port0_tx_done_flag),
	.port0_rx_done_flag(port0_rx_done_flag), .port0_irq(port0_irq), .clock_divide(clock_divide));
`default_nettype wire

// >>> dual_serial_port_addr_match_test.sv
/* Self-checking bench: APB register tasks, port 1 frames through the remote node,
   port 0 events driven directly. Assumes the block answers every access in order. */
`default_nettype none
module dual_serial_port_addr_match_test import serial_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic         rxd, tick, txd, irq0, irq1, tx0, rx0, match0, oe;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rdat;
	logic [1:0]   cdiv;
	logic [7:0]   byte0;
	logic [10:0]  f;
	logic [7:0]   ctl [3] = '{8'h40, 8'hc8, 8'h88};
	port_events_t ev0;
	int           fails, cmp_count;
	dual_serial_port_addr_match dual_serial_port_addr_match_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .port1_rxd_in(rxd), .port1_rxd_out(), .port1_rxd_oe(oe),
		.port1_txd(txd), .port1_baud_tick(tick), .port0_events(ev0), .port0_rx_byte(byte0),
		.port0_tx_done_flag(tx0), .port0_rx_done_flag(rx0), .port0_addr_match(match0),
		.port0_irq(irq0), .port1_irq(irq1), .clock_divide(cdiv));
	serial_remote_node serial_remote_node_i (.pclk(pclk), .presetn(presetn), .txd(txd), .rxd(rxd),
		.baud_tick(tick));
	always #20 pclk = ~pclk;
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdat, {24'h0, exp});
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		{pclk, presetn, psel, penable, pwrite, tx0, rx0} = '0;
		{paddr, pwdata, byte0, ev0} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_POWER, 8'h40);
		rd(IDX_P1_CTRL, 8'h00);
		rd(IDX_STATUS, 8'h00);
		wr(IDX_P1_PORT0_SLAVE_ADDRESS, 8'h77);
		rd(IDX_P1_PORT0_SLAVE_ADDRESS, 8'h77);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		$display("test registers done");
		wr(IDX_CONFIG, 8'h40);
		for (int m = 0; m < 3; m++) begin
			wr(IDX_P1_CTRL, ctl[m]);
			wr(IDX_P1_BUF, 8'ha5);
			serial_remote_node_i.recv(f, m ? 11 : 10);
			chk({21'h0, f}, {21'h0, 2'b11, 8'ha5, 1'b0});
			rd(IDX_P1_CTRL, ctl[m] | 8'h02);
			rd(IDX_STATUS, 8'h00);
			chk({31'h0, irq1}, 32'h1);
		end
		wr(IDX_P1_CTRL, 8'h00);
		wr(IDX_P1_BUF, 8'h5a);
		@(posedge pclk);
		chk({31'h0, oe}, 32'h1);
		repeat (90) @(posedge pclk);
		chk({31'h0, irq1}, 32'h0);
		repeat (10) @(posedge pclk);
		rd(IDX_P1_CTRL, 8'h02);
		$display("test transmit done");
		wr(IDX_P1_CTRL, 8'h40);
		serial_remote_node_i.send({2'b11, 8'h3c, 1'b0}, 10);
		rd(IDX_P1_CTRL, 8'h40);
		rd(IDX_P1_BUF, 8'h00);
		wr(IDX_POWER, 8'ha0);
		rd(IDX_POWER, 8'ha0);
		wr(IDX_P1_CTRL, 8'h50);
		serial_remote_node_i.send({2'b11, 8'h3c, 1'b0}, 10);
		chk({30'h0, cdiv}, 32'h1);
		rd(IDX_P1_CTRL, 8'h55);
		rd(IDX_P1_BUF, 8'h3c);
		rd(IDX_STATUS, 8'h00);
		for (int b = 0; b < 3; b++) begin
			wr(IDX_P1_CTRL, b ? 8'hf0 : 8'h70);
			serial_remote_node_i.send({1'b1, b == 2, 8'h22, 1'b0}, b ? 11 : 10);
			chk({31'h0, irq1}, 32'(b == 2));
		end
		rd(IDX_P1_BUF, 8'h22);
		wr(IDX_CONFIG, 8'hc0);
		rd(IDX_P1_CTRL, 8'hf5);
		$display("test receive done");
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk) ev0 <= i ? 5'h04 : 5'h10;
			@(posedge pclk) ev0 <= '0;
			rd(IDX_STATUS, i ? 8'h01 : 8'h02);
			wr(IDX_POWER, 8'ha0);
			rd(IDX_POWER, 8'h60);
			@(posedge pclk) ev0 <= i ? 5'h02 : 5'h08;
			@(posedge pclk) ev0 <= '0;
			rd(IDX_STATUS, 8'h00);
		end
		wr(IDX_POWER, 8'ha0);
		rd(IDX_POWER, 8'ha0);
		$display("test switchback done");
		wr(IDX_P0_PORT0_SLAVE_ADDRESS, 8'h5a);
		wr(IDX_P0_MASK, 8'hf0);
		for (int i = 0; i < 3; i++) begin
			if (i == 2)
				wr(IDX_P0_MASK, 8'h00);
			@(posedge pclk) byte0 <= i ? 8'h63 : 8'h53;
			repeat (2) @(posedge pclk);
			chk({31'h0, match0}, 32'(i != 1));
		end
		@(posedge pclk) rx0 <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({31'h0, irq0}, 32'h1);
		$display("test port 0 done");
		summarize;
	end
	initial begin
		repeat (30000) @(posedge pclk);
		fails++;
		summarize;
	end
endmodule
`default_nettype wire
